//--- logic/rail_seq_fsm.sv
// control state machine of a four-rail power sequencer
// assumes comparator levels arrive asynchronously; timer lengths are static
// Functional notes
// - rising up command edge starts power-up
// - falling down command edge starts power-down
// - fault holds until up command low
// - open-drain fault pulled low on fault
// - reverse shutdown walks only enabled rails backwards
// - regulation timeout during power-up triggers reverse
// - good rail drop before next good reverses
// - down during power-up reverses enabled rails
// - out-of-order drives all outputs low immediately
// - good rail drops while next regulating
// - on without enable, power-up only, out-of-order
// - up during power-down resumes after delay
// - step delay holds next enable and flags
// - power good drops at once on down
// - disabled timeout waits forever for rail
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.svh"
module rail_seq_fsm (
    input  wire logic                   clk,              // 100 MHz clock
    input  wire logic                   reset,            // sync reset, active high
    input  wire logic                   up_cmd_in,        // start-up comparator level
    input  wire logic                   down_cmd_n_in,    // shut-down comparator, active low
    input  wire logic [3:0]             rail_on_in,       // per-rail above on level
    input  wire logic [3:0]             rail_off_n_in,    // per-rail above off level
    input  wire logic [`TMR_W-1:0]      step_delay_cyc,   // inter-step delay, 0 = none
    input  wire logic [`TMR_W-1:0]      reg_timeout_cyc,  // regulation timeout, 0 = off
    output var  rail_seq_pkg::seq_out_t outs,             // enables and flags
    output logic                        fault_n_oe        // high while pulling fault low
);
    rail_seq_pkg::seq_state_t state_ff, nxt_state;
    rail_seq_pkg::cmp_bus_t   cmp;
    logic                     up_rise, down_fall;
    logic [3:0]               en_ff, nxt_en;
    logic [`TMR_W-1:0]        dly_ff, nxt_dly;
    logic [`TMR_W-1:0]        reg_ff, nxt_reg;
    logic                     done_ff, nxt_done;
    logic                     pg_ff, nxt_pg;
    logic                     arm_ff, nxt_arm;

    // ==========================================
    // input conditioning
    rail_seq_sync u_sync (
        .clk       (clk),
        .reset     (reset),
        .raw       ('{up_cmd: up_cmd_in, down_cmd_n: down_cmd_n_in,
                      rail_on: rail_on_in, rail_off_n: rail_off_n_in}),
        .sync      (cmp),
        .up_rise   (up_rise),
        .down_fall (down_fall)
    );

    // index of highest enabled rail, or 0 when no rail is enabled
    function automatic logic [`RAIL_IDX_W-1:0] top_idx(input logic [3:0] v);
        top_idx = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
    endfunction : top_idx

    // ==========================================
    // monitoring decodes
    wire [`RAIL_IDX_W-1:0] hi_idx    = top_idx(en_ff);
    wire [`RAIL_IDX_W-1:0] nxt_idx   = hi_idx + 2'h1;
    wire                   any_en    = |en_ff;
    wire [3:0]             top_bit   = 4'h1 << hi_idx;
    // a freshly enabled rail is not yet good: it may sit below off while ramping
    wire [3:0]             good_mask = (state_ff == rail_seq_pkg::ST_UP) ?
                                       ((en_ff & ~top_bit) | (arm_ff ? top_bit : 4'h0)) : en_ff;
    wire                   hi_good   = cmp.rail_on[hi_idx];
    wire                   dly_done  = (dly_ff == `STEP_DLY_RESET);
    wire                   reg_on    = (reg_timeout_cyc != `REG_TMO_RESET);
    wire                   reg_exp   = reg_on && (reg_ff == reg_timeout_cyc);
    // rail good but below off while next not yet in regulation
    wire [3:0]             next_reg  = {1'b0, cmp.rail_on[3:1]};
    wire [3:0]             drop      = good_mask & ~cmp.rail_off_n;
    wire                   drop_rev  = |(drop & ~next_reg);
    wire                   drop_ooo  = |(drop & next_reg & {1'b0, en_ff[3:1]});
    wire                   on_no_en  = |(cmp.rail_on & ~en_ff);
    wire                   ooo       = drop_ooo ||
                                       (state_ff == rail_seq_pkg::ST_UP && on_no_en);

    // ==========================================
    // next state and output values
    always_comb begin
        nxt_state = state_ff;
        nxt_en    = en_ff;
        nxt_dly   = dly_done ? dly_ff : dly_ff - 24'h000001;
        nxt_reg   = reg_ff;
        nxt_done  = done_ff;
        nxt_pg    = pg_ff;
        nxt_arm   = arm_ff;
        unique case (state_ff)
            rail_seq_pkg::ST_OFF: begin
                if (up_rise) begin
                    nxt_state = rail_seq_pkg::ST_UP;
                    nxt_en    = 4'h1;
                    nxt_reg   = 24'h000000;
                end
            end
            rail_seq_pkg::ST_UP: begin
                // timeout only runs until the top rail reaches its on level
                nxt_reg = (reg_exp || hi_good) ? reg_ff : reg_ff + 24'h000001;
                if (down_fall) begin
                    nxt_state = rail_seq_pkg::ST_REV;
                    nxt_pg    = 1'b0;
                    nxt_dly   = step_delay_cyc;
                end else if (reg_exp && !hi_good) begin
                    nxt_state = rail_seq_pkg::ST_REV;
                    nxt_en    = en_ff & ~(4'h1 << hi_idx);
                    nxt_dly   = step_delay_cyc;
                end else if (drop_rev) begin
                    nxt_state = rail_seq_pkg::ST_REV;
                    nxt_dly   = step_delay_cyc;
                end else if (hi_good && !arm_ff) begin
                    nxt_dly   = step_delay_cyc;
                    nxt_arm   = 1'b1;
                end else if (hi_good && dly_done) begin
                    nxt_arm   = 1'b0;
                    if (en_ff[3]) begin
                        nxt_state = rail_seq_pkg::ST_ON;
                        nxt_done  = 1'b1;
                        nxt_pg    = 1'b1;
                    end else begin
                        nxt_en[nxt_idx] = 1'b1;
                        nxt_reg = 24'h000000;
                    end
                end
            end
            rail_seq_pkg::ST_ON: begin
                if (down_fall) begin
                    nxt_state = rail_seq_pkg::ST_DOWN;
                    nxt_pg    = 1'b0;
                    nxt_en[3] = 1'b0;
                end
            end
            rail_seq_pkg::ST_DOWN, rail_seq_pkg::ST_REV: begin
                nxt_pg = 1'b0;
                if (up_rise && state_ff == rail_seq_pkg::ST_DOWN) begin
                    nxt_state = rail_seq_pkg::ST_UP;
                    nxt_reg   = 24'h000000;
                end else if (!any_en) begin
                    if (cmp.rail_off_n[0] == 1'b0 && dly_done) begin
                        nxt_state = state_ff == rail_seq_pkg::ST_REV ?
                                    rail_seq_pkg::ST_FAULT : rail_seq_pkg::ST_OFF;
                        nxt_done  = 1'b0;
                    end
                end else if (!arm_ff) begin
                    // walk back only over enabled rails, once the one above is off
                    if (hi_idx == 2'h3 || !cmp.rail_off_n[nxt_idx]) begin
                        nxt_dly = step_delay_cyc;
                        nxt_arm = 1'b1;
                    end
                end else if (dly_done) begin
                    nxt_en[hi_idx] = 1'b0;
                    nxt_arm        = 1'b0;
                end
            end
            rail_seq_pkg::ST_FAULT: begin
                if (!cmp.up_cmd) begin
                    nxt_state = rail_seq_pkg::ST_OFF;
                end
            end
            default: begin
                nxt_state = rail_seq_pkg::ST_OFF;
            end
        endcase
        if (ooo && state_ff != rail_seq_pkg::ST_FAULT) begin
            nxt_state = rail_seq_pkg::ST_FAULT;
            nxt_en    = 4'h0;
            nxt_done  = 1'b0;
            nxt_pg    = 1'b0;
        end
        // every state entry starts with the step delay unarmed
        if (nxt_state != state_ff) begin
            nxt_arm = 1'b0;
        end
    end

    // ==========================================
    // state registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= rail_seq_pkg::ST_OFF;
            en_ff    <= 4'h0;
            dly_ff   <= `STEP_DLY_RESET;
            reg_ff   <= `REG_TMO_RESET;
            done_ff  <= 1'b0;
            pg_ff    <= 1'b0;
            arm_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            en_ff    <= nxt_en;
            dly_ff   <= nxt_dly;
            reg_ff   <= nxt_reg;
            done_ff  <= nxt_done;
            pg_ff    <= nxt_pg;
            arm_ff   <= nxt_arm;
        end
    end

    // fault is open drain: drive low only in fault
    assign fault_n_oe                  = (state_ff == rail_seq_pkg::ST_FAULT);
    assign outs.rail_enable_out        = en_ff;
    assign outs.sequence_complete_flag = done_ff;
    assign outs.power_good_flag        = pg_ff;
    assign outs.fault_n                = 1'b0;

    // ==========================================
    // checks
    sequence s_down_seen;
        down_fall && state_ff == rail_seq_pkg::ST_ON;
    endsequence

    a_up_starts : assert property (@(posedge clk) disable iff (reset)
        (up_rise && state_ff == rail_seq_pkg::ST_OFF && !ooo) |=> en_ff == 4'h1)
        else $error("power-up did not start");
    a_down_starts : assert property (@(posedge clk) disable iff (reset)
        s_down_seen |=> state_ff == rail_seq_pkg::ST_DOWN || state_ff == rail_seq_pkg::ST_FAULT)
        else $error("power-down did not start");
    a_fault_latch : assert property (@(posedge clk) disable iff (reset)
        (state_ff == rail_seq_pkg::ST_FAULT && cmp.up_cmd) |=> state_ff == rail_seq_pkg::ST_FAULT)
        else $error("fault left while up high");
    a_fault_pin : assert property (@(posedge clk) disable iff (reset)
        fault_n_oe == (state_ff == rail_seq_pkg::ST_FAULT) && outs.fault_n == 1'b0)
        else $error("fault pin wrong");
    a_rev_no_grow : assert property (@(posedge clk) disable iff (reset)
        state_ff == rail_seq_pkg::ST_REV |=> (en_ff & ~$past(en_ff)) == 4'h0)
        else $error("reverse enabled a rail");
    a_ooo_clear : assert property (@(posedge clk) disable iff (reset)
        (ooo && state_ff != rail_seq_pkg::ST_FAULT) |=> en_ff == 4'h0 && !pg_ff && !done_ff)
        else $error("out of order left outputs up");
    a_pg_drop : assert property (@(posedge clk) disable iff (reset)
        s_down_seen |=> !pg_ff)
        else $error("power good held after down");
    a_abort_up : assert property (@(posedge clk) disable iff (reset)
        (down_fall && state_ff == rail_seq_pkg::ST_UP && !ooo) |=> state_ff == rail_seq_pkg::ST_REV)
        else $error("down during up not reversed");
    a_no_timeout : assert property (@(posedge clk) disable iff (reset)
        (!reg_on && state_ff == rail_seq_pkg::ST_UP && !hi_good && !down_fall && !ooo && !drop_rev)
        |=> state_ff == rail_seq_pkg::ST_UP)
        else $error("left power-up with timeout off");
endmodule : rail_seq_fsm
`default_nettype wire

//--- logic/rail_seq_defs.svh
// constants for the four-rail power sequencer control machine
// assumes a 100 MHz clock; timer lengths arrive as cycle counts on ports
`ifndef RAIL_SEQ_DEFS_SVH
`define RAIL_SEQ_DEFS_SVH
`define RAIL_COUNT        3'h4
`define RAIL_IDX_W        2
`define TMR_W             24
`define CLK_PERIOD_NS     10
`define START_DELAY_US    2800
`define START_DELAY_CYC   ((`START_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_DLY_RESET    24'h000000
`define REG_TMO_RESET     24'h000000
`endif

//--- logic/rail_seq_pkg.sv
// types shared by the sequencer files
// assumes rail_seq_defs.svh is on the include path
package rail_seq_pkg;
    // ==========================================
    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_OFF   = 6'h01,
        ST_UP    = 6'h02,
        ST_ON    = 6'h04,
        ST_DOWN  = 6'h08,
        ST_FAULT = 6'h10,
        ST_REV   = 6'h20
    } seq_state_t;

    // synchronised comparator results
    typedef struct packed {
        logic       up_cmd;
        logic       down_cmd_n;
        logic [3:0] rail_on;
        logic [3:0] rail_off_n;
    } cmp_bus_t;

    // outputs toward the regulators and host
    typedef struct packed {
        logic [3:0] rail_enable_out;
        logic       sequence_complete_flag;
        logic       power_good_flag;
        logic       fault_n;
    } seq_out_t;
endpackage : rail_seq_pkg

//--- logic/rail_seq_sync.sv
// two-stage synchroniser for all comparator inputs plus edge detector for the up and down commands
// assumes inputs come straight from analog comparators, unrelated to clk
`timescale 1ns/1ps
`default_nettype none
module rail_seq_sync (
    input  wire logic                  clk,        // system clock
    input  wire logic                  reset,      // sync reset, active high
    input  wire rail_seq_pkg::cmp_bus_t raw,       // raw comparator levels
    output var  rail_seq_pkg::cmp_bus_t sync,      // synchronised levels
    output logic                       up_rise,    // up command rising edge
    output logic                       down_fall   // down command falling edge
);
    rail_seq_pkg::cmp_bus_t meta_ff;
    rail_seq_pkg::cmp_bus_t sync_ff;
    rail_seq_pkg::cmp_bus_t last_ff;

    // ==========================================
    // synchroniser: only stage two reads stage one
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_ff <= '{up_cmd: 1'b0, down_cmd_n: 1'b1, rail_on: 4'h0, rail_off_n: 4'h0};
            sync_ff <= '{up_cmd: 1'b0, down_cmd_n: 1'b1, rail_on: 4'h0, rail_off_n: 4'h0};
            last_ff <= '{up_cmd: 1'b0, down_cmd_n: 1'b1, rail_on: 4'h0, rail_off_n: 4'h0};
        end else begin
            meta_ff <= raw;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    // edge pulses, one cycle each
    assign sync      = sync_ff;
    assign up_rise   = sync_ff.up_cmd & ~last_ff.up_cmd;
    assign down_fall = ~sync_ff.down_cmd_n & last_ff.down_cmd_n;

    a_up_edge_pulse : assert property (@(posedge clk) disable iff (reset)
        up_rise |=> !up_rise)
        else $error("up edge pulse longer than one cycle");
endmodule : rail_seq_sync
`default_nettype wire

//--- sim/rail_reg_model.sv
// regulator bank model: each rail output ramps up with its enable
// assumes the bench drives the stuck and drop fault masks
`timescale 1ns/1ps
`default_nettype none
module rail_reg_model (
    input  wire logic       clk,        // system clock
    input  wire logic [3:0] enable,     // regulator enables
    input  wire logic [3:0] stuck,      // rail never reaches on level
    input  wire logic [3:0] drop,       // rail collapses at once
    output logic      [3:0] rail_on,    // above on level
    output logic      [3:0] rail_off_n  // above off level
);
    // ==========================================
    // output level per rail, 0 to 8
    int lvl [4] = '{0, 0, 0, 0};
    // moves on the falling edge, clear of the sampling edge
    always @(negedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (drop[i]) begin
                lvl[i] <= 0;
            end else if (enable[i] && !stuck[i] && lvl[i] < 8) begin
                lvl[i] <= lvl[i] + 1;
            end else if (!enable[i] && lvl[i] > 0) begin
                lvl[i] <= lvl[i] - 1;
            end
        end
    end
    // on level only when fully up; discharge passes on first
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            rail_on[i] = (lvl[i] == 8);
            rail_off_n[i] = (lvl[i] > 2);
        end
    end
endmodule : rail_reg_model
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the four-rail sequencer control machine
// assumes rail_seq_defs.svh on the include path and the regulator model
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb;
    // ==========================================
    // stimulus and observation
    logic                   clk = 1'b0;
    logic                   reset = 1'b1;
    logic                   up = 1'b0;
    logic                   down_n = 1'b1;
    logic [3:0]             stuck = 4'h0;
    logic [3:0]             drop = 4'h0;
    logic [`TMR_W-1:0]      step = '0;
    logic [`TMR_W-1:0]      tmo = '0;
    logic [3:0]             rail_on;
    logic [3:0]             rail_off_n;
    logic                   fault_n_oe;
    rail_seq_pkg::seq_out_t outs;
    int                     fails = 0;
    int                     comparisons = 0;
    int                     cyc = 0;
    // open-drain fault line with its pull-up
    wire fault_pin = fault_n_oe ? outs.fault_n : 1'b1;

    rail_seq_fsm rail_seq_fsm_inst (.clk(clk), .reset(reset), .up_cmd_in(up), .down_cmd_n_in(down_n),
        .rail_on_in(rail_on), .rail_off_n_in(rail_off_n), .step_delay_cyc(step),
        .reg_timeout_cyc(tmo), .outs(outs), .fault_n_oe(fault_n_oe));
    rail_reg_model rail_reg_model_inst (.clk(clk), .enable(outs.rail_enable_out), .stuck(stuck),
        .drop(drop), .rail_on(rail_on), .rail_off_n(rail_off_n));

    // clock and hang guard
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            complete_run();
        end
    end

    // ==========================================
    // helpers
    task automatic complete_run;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    // timers are static, so each scenario except s_power_down starts from a fresh reset
    task automatic rst(input int sd, input int rt);
        up = 1'b0; down_n = 1'b1; stuck = 4'h0; drop = 4'h0;
        step = `TMR_W'(sd); tmo = `TMR_W'(rt); reset = 1'b1; // supply ideal from time zero
        repeat (6) @(negedge clk);
        reset = 1'b0;
        repeat (10) @(negedge clk);
    endtask : rst
    task automatic wait_en(input logic [3:0] v, input int n);
        for (int i = 0; i < n && outs.rail_enable_out !== v; i++) @(negedge clk);
    endtask : wait_en
    task automatic go_on;
        up = 1'b1;
        for (int i = 0; i < 600 && outs.power_good_flag !== 1'b1; i++) @(negedge clk);
    endtask : go_on

    // ==========================================
    // scenarios
    task automatic s_power_up;
        logic [3:0] prev;
        int t3;
        prev = 4'h0; t3 = 0;
        rst(20, 0);
        up = 1'b1;
        for (int i = 0; i < 600 && outs.power_good_flag !== 1'b1; i++) begin
            @(negedge clk);
            if (rail_on[3] === 1'b1 && t3 == 0) t3 = cyc;
            if (outs.rail_enable_out !== prev) begin
                `CHK("enable step", {prev[2:0], 1'b1}, outs.rail_enable_out)
                prev = outs.rail_enable_out;
            end
        end
        `CHK("enables at good", 4'hF, outs.rail_enable_out)
        `CHK("complete flag", 1'b1, outs.sequence_complete_flag)
        `CHK("delay held", 1'b1, (cyc - t3) >= 20)
    endtask : s_power_up
    task automatic s_power_down;
        down_n = 1'b0;
        for (int i = 0; i < 8 && outs.power_good_flag !== 1'b0; i++) @(negedge clk);
        `CHK("good dropped", 1'b0, outs.power_good_flag)
        `CHK("low rails held", 1'b1, outs.rail_enable_out[0])
        wait_en(4'h0, 600);
        `CHK("all off", 4'h0, outs.rail_enable_out)
        for (int i = 0; i < 50 && outs.sequence_complete_flag !== 1'b0; i++) @(negedge clk);
        `CHK("complete low", 1'b0, outs.sequence_complete_flag)
        `CHK("no fault", 1'b1, fault_pin)
    endtask : s_power_down
    task automatic s_timeout;
        logic bad;
        bad = 1'b0;
        rst(20, 60);
        stuck = 4'h4;
        up = 1'b1;
        for (int i = 0; i < 800 && fault_pin !== 1'b0; i++) begin
            @(negedge clk);
            if (outs.rail_enable_out[3] !== 1'b0) bad = 1'b1;
        end
        `CHK("fault on timeout", 1'b0, fault_pin)
        `CHK("top never on", 1'b0, bad)
        wait_en(4'h0, 300);
        `CHK("reversed off", 4'h0, outs.rail_enable_out)
        repeat (40) @(negedge clk);
        `CHK("fault latched", 1'b0, fault_pin)
        up = 1'b0;
        repeat (8) @(negedge clk);
        `CHK("fault released", 1'b1, fault_pin)
    endtask : s_timeout
    task automatic s_wait_forever;
        rst(20, 0);
        stuck = 4'h1;
        up = 1'b1;
        repeat (400) @(negedge clk);
        `CHK("still waiting", 4'h1, outs.rail_enable_out)
        `CHK("no fault", 1'b1, fault_pin)
    endtask : s_wait_forever
    task automatic s_down_mid_up;
        logic bad;
        bad = 1'b0;
        rst(20, 0);
        up = 1'b1;
        wait_en(4'h3, 300);
        down_n = 1'b0;
        for (int i = 0; i < 300 && outs.rail_enable_out !== 4'h0; i++) begin
            @(negedge clk);
            if (outs.rail_enable_out[2] !== 1'b0) bad = 1'b1;
        end
        `CHK("abandoned up", 4'h0, outs.rail_enable_out)
        `CHK("no further rail", 1'b0, bad)
    endtask : s_down_mid_up
    task automatic s_out_of_order;
        rst(20, 0);
        go_on();
        drop = 4'h2;
        for (int i = 0; i < 8 && outs.rail_enable_out !== 4'h0; i++) @(negedge clk);
        `CHK("enables cut", 4'h0, outs.rail_enable_out)
        `CHK("complete cut", 1'b0, outs.sequence_complete_flag)
        `CHK("good cut", 1'b0, outs.power_good_flag)
    endtask : s_out_of_order
    task automatic s_resume;
        rst(20, 0);
        go_on();
        down_n = 1'b0;
        wait_en(4'h7, 100);
        up = 1'b0;
        repeat (4) @(negedge clk);
        up = 1'b1;
        for (int i = 0; i < 600 && outs.power_good_flag !== 1'b1; i++) @(negedge clk);
        `CHK("resumed up", 4'hF, outs.rail_enable_out)
        `CHK("good again", 1'b1, outs.power_good_flag)
    endtask : s_resume

    // main sequence
    initial begin
        s_power_up();
        s_power_down();
        s_timeout();
        s_wait_forever();
        s_down_mid_up();
        s_out_of_order();
        s_resume();
        complete_run();
    end
endmodule : tb
`default_nettype wire
